// File: hw/ltx_regs.svh
`ifndef LTX_REGS_SVH
`define LTX_REGS_SVH

// Default parallel word width (times-eight mode)
`define LTX_WORD_W_DEF   8
// Boundary counter width, compare value and reset value
`define LTX_CNT_W        2
`define LTX_CNT_LOAD     2'h3
`define LTX_CNT_RST      2'h0
// Reset levels of the differential output pairs
`define LTX_DATA_P_RST   1'h0
`define LTX_CLK_P_RST    1'h0

`endif

// File: hw/ltx_pkg.sv
`default_nettype none
`include "ltx_regs.svh"

package ltx_pkg;

    // Byte boundary down counter value
    typedef logic [`LTX_CNT_W-1:0] ltx_cnt_t;

endpackage

`default_nettype wire

// File: hw/ltx_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ltx_edge_sync
    import ltx_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Clock sampled from outside the domain
    input  wire logic async_in,
    // Synchronised level, delayed level and edge pulses
    output logic      level,
    output logic      level_d,
    output logic      rise,
    output logic      fall
);

    logic meta_reg;
    logic sync_reg;
    logic dly_reg;

    // Two flops before use; only sync_reg reads meta_reg
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            meta_reg <= 1'h0;
            sync_reg <= 1'h0;
            dly_reg  <= 1'h0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
            dly_reg  <= sync_reg;
        end
    end

    // Edge pulses last one cycle of clk
    assign level   = sync_reg;
    assign level_d = dly_reg;
    assign rise    = sync_reg & ~dly_reg;
    assign fall    = ~sync_reg & dly_reg;

endmodule

`default_nettype wire

// File: hw/ltx_tx_serializer_top.sv
// How it works
// R1 - Capture parallel word on slow word clock
// R2 - Two parallel-in serial-out chains shift bits
// R3 - Chains advance on fast bit clock edges
// R4 - Even bits load one chain, odd other
// R5 - Two-bit down counter tracks byte boundary
// R6 - Counter idle until first slow clock edge
// R7 - Count equal three enables chain load
// R8 - Counter and compare fix byte start
// R9 - Even retimed on fall, odd on rise
// R10 - Fast clock level selects even or odd
// R11 - Word width sets serialization factor
// R12 - Surroundings hold reset at start
// R13 - Fast clock is four times slow
// R14 - Reference input clock rates per mode
// R15 - Clock forwarded alongside serial data
// R16 - One serial stream on one pair
// R17 - Bit zero first, even/odd alternate
`timescale 1ns/1ps
`default_nettype none
`include "ltx_regs.svh"

module ltx_tx_serializer_top
    import ltx_pkg::*;
#(
    parameter int WORD_W = `LTX_WORD_W_DEF
)
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Link clocks from the clock source
    input  wire logic              fast_bit_clock,
    input  wire logic              slow_word_clock,
    // Parallel word from internal logic
    input  wire logic [WORD_W-1:0] data_in,
    // Serial data pair
    output logic                   tx_data_p,
    output logic                   tx_data_n,
    // Forwarded clock pair
    output logic                   tx_clk_p,
    output logic                   tx_clk_n
);

    localparam int HALF = WORD_W / 2;
    // Last count of a word: 0 for eight bits, 2 for four bits, 3 for two
    localparam ltx_cnt_t CNT_END = ltx_cnt_t'(4 - HALF);

    // Timing, in clk cycles, with a fast period of twelve clk:
    // - a link clock pin edge becomes an edge pulse two clk edges later,
    //   give or take one, depending on where the pin moves between edges;
    // - the retime flop takes its bit on that pulse and the output flop
    //   one clk after it, so the serial bit trails the pin edge by about
    //   three to four clk;
    // - each serial bit stands half a fast period, quantised to clk.
    // Limitation: clk must run several times faster than the fast bit
    // clock, or edge pulses merge in the synchronisers and bits are lost.
    // Odd word widths cannot be split into even and odd lanes and are not
    // supported; WORD_W is even, from 2 to 8.

    // Capture bank, chain contents and their load values
    logic [WORD_W-1:0] word_capture_reg;
    logic [HALF-1:0]   even_chain_reg;
    logic [HALF-1:0]   odd_chain_reg;
    logic [HALF-1:0]   even_load;
    logic [HALF-1:0]   odd_load;

    // Boundary counter
    ltx_cnt_t          cnt_reg;
    ltx_cnt_t          cnt_next;
    logic              started_reg;

    // Retime and output flops
    logic              even_rt_reg;
    logic              odd_rt_reg;
    logic              data_p_reg;
    logic              clk_p_reg;

    // Link clocks as seen in the clk domain
    logic              fast_lvl_d;
    logic              fast_rise;
    logic              fast_fall;
    logic              slow_lvl_d;
    logic              slow_rise;

    // Decoded controls and the even/odd select
    logic              cmp_hit;
    logic              chain_load;
    logic              chain_shift;
    logic              even_odd_select;

    // Both link clocks are sampled by clk and turned into edge pulses
    // A rise seen when reset lifts with the fast pin high is harmless:
    // nothing moves before the first slow rise
    ltx_edge_sync u_fast_sync
    (
        .clk      (clk),
        .rstn     (rstn),
        .async_in (fast_bit_clock),
        .level    (),
        .level_d  (fast_lvl_d),
        .rise     (fast_rise),
        .fall     (fast_fall)
    );

    ltx_edge_sync u_slow_sync
    (
        .clk      (clk),
        .rstn     (rstn),
        .async_in (slow_word_clock),
        .level    (),
        .level_d  (slow_lvl_d),
        .rise     (slow_rise),
        .fall     ()
    );

    // Word capture bank, one flop per input bit
    always_ff @(posedge clk)
    begin
        if (!rstn)
            word_capture_reg <= '0;
        else if (slow_rise)
            word_capture_reg <= data_in; // R1 R11
    end

    // Split the captured word into even and odd lanes
    // Lane bit i carries word bit 2i or 2i+1, so lane bit zero leaves first
    generate
        for (genvar i = 0; i < HALF; i++)
        begin : g_split
            assign even_load[i] = word_capture_reg[2*i];   // R4
            assign odd_load[i]  = word_capture_reg[2*i+1]; // R4
        end
    endgenerate

    // Boundary compare and chain controls
    // Step down, and wrap back to the load count after the last bit pair
    assign cmp_hit     = (cnt_reg == `LTX_CNT_LOAD);         // R7
    assign chain_load  = started_reg & fast_rise & cmp_hit;  // R7 R8
    assign chain_shift = started_reg & fast_rise & ~cmp_hit; // R3
    assign cnt_next    = (cnt_reg == CNT_END) ? `LTX_CNT_LOAD : ltx_cnt_t'(cnt_reg - 2'h1);

    // Counter waits for the first slow edge so the first load sees a captured word
    always_ff @(posedge clk)
    begin
        if (!rstn)
            started_reg <= 1'h0;
        else if (slow_rise)
            started_reg <= 1'h1; // R6
    end

    // Down counter stepped by each fast rising edge after the first slow rise
    // The wrap value CNT_END gives HALF fast rises per word
    always_ff @(posedge clk)
    begin
        if (!rstn)
            cnt_reg <= `LTX_CNT_RST;
        else if (started_reg && fast_rise)
            cnt_reg <= cnt_next; // R5 R8
    end

    // Two chains: load on boundary, otherwise shift toward bit zero
    // Load and shift never share an edge, so no word is dropped at a boundary
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            even_chain_reg <= '0;
            odd_chain_reg  <= '0;
        end
        else if (chain_load)
        begin
            even_chain_reg <= even_load; // R2 R4
            odd_chain_reg  <= odd_load;  // R2 R4
        end
        else if (chain_shift)
        begin
            even_chain_reg <= even_chain_reg >> 1; // R2 R3 R17
            odd_chain_reg  <= odd_chain_reg >> 1;  // R2 R3 R17
        end
    end

    // Retime even on fall, odd on rise; odd reads the chain before it moves
    // Even bits thus stand in the low phase, odd bits in the high phase
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            even_rt_reg <= 1'h0;
            odd_rt_reg  <= 1'h0;
        end
        else
        begin
            if (fast_fall)
                even_rt_reg <= even_chain_reg[0]; // R9
            if (fast_rise)
                odd_rt_reg <= odd_chain_reg[0];   // R9
        end
    end

    // Delayed level lines the select up with the retime flop updates
    // Using the undelayed level would show the stale lane for one clk
    assign even_odd_select = fast_lvl_d ? odd_rt_reg : even_rt_reg; // R10 R17

    // Output pairs registered; the forwarded clock follows the word clock
    // Both legs come from one flop so they switch in the same clk
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            data_p_reg <= `LTX_DATA_P_RST;
            clk_p_reg  <= `LTX_CLK_P_RST;
        end
        else
        begin
            data_p_reg <= even_odd_select; // R16
            clk_p_reg  <= slow_lvl_d;      // R15
        end
    end

    // Drive both legs of each pair
    assign tx_data_p = data_p_reg;  // R16
    assign tx_data_n = ~data_p_reg; // R16
    assign tx_clk_p  = clk_p_reg;   // R15
    assign tx_clk_n  = ~clk_p_reg;  // R15

endmodule

`default_nettype wire

// File: verif/ltx_tx_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ltx_tx_checker
    import ltx_pkg::*;
#(
    parameter int WORD_W = 8
)
(
    // Clock and reset
    input wire logic              clk,
    input wire logic              rstn,
    // Link clocks and word
    input wire logic              fast_bit_clock,
    input wire logic              slow_word_clock,
    input wire logic [WORD_W-1:0] data_in,
    // Output pairs
    input wire logic              tx_data_p,
    input wire logic              tx_data_n,
    input wire logic              tx_clk_p,
    input wire logic              tx_clk_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic started_reg;
    // Nothing may be sent before a slow rise
    always_ff @(posedge clk)
    begin
        started_reg <= rstn & (started_reg | slow_word_clock);
    end
    sequence hold_bit;
        $stable(tx_data_p)[*4];
    endsequence
    data_pair_a: assert property (tx_data_n == !tx_data_p) else $error("data pair");
    clk_pair_a: assert property (tx_clk_n == !tx_clk_p) else $error("clock pair");
    reset_out_a: assert property ($rose(rstn) |-> !tx_data_p && !tx_clk_p)
        else $error("reset level");
    fwd_rise_a: assert property ($rose(slow_word_clock) |-> ##[2:6] tx_clk_p)
        else $error("clock rise");
    fwd_fall_a: assert property ($fell(slow_word_clock) |-> ##[2:6] !tx_clk_p)
        else $error("clock fall");
    fwd_hold_a: assert property ($rose(tx_clk_p) |=> tx_clk_p[*8]) else $error("clock hold");
    bit_hold_a: assert property ($changed(tx_data_p) |=> hold_bit) else $error("bit hold");
    idle_zero_a: assert property (!started_reg |-> !tx_data_p) else $error("early data");
endmodule
bind ltx_tx_serializer_top ltx_tx_checker #(.WORD_W(WORD_W)) u_chk (.clk(clk), .rstn(rstn),
    .fast_bit_clock(fast_bit_clock), .slow_word_clock(slow_word_clock), .data_in(data_in),
    .tx_data_p(tx_data_p), .tx_data_n(tx_data_n), .tx_clk_p(tx_clk_p), .tx_clk_n(tx_clk_n));
`default_nettype wire

// File: verif/ltx_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module ltx_rx_model
(
    // Link from the transmitter
    input wire logic fast_bit_clock,
    input wire logic tx_data_p
);
    logic bits[$];
    // Sample 8 ns past the next edge, late in the bit that the previous edge launched
    always @(fast_bit_clock)
    begin
        #8;
        bits.push_back(tx_data_p);
    end
endmodule
`default_nettype wire

// File: verif/ltx_tx_serializer_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ltx_tx_serializer_top_tb;
    logic       clk;
    logic       rstn;
    logic       fast_bit_clock;
    logic       slow_word_clock;
    logic [7:0] data_in;
    logic       tx_data_p;
    int         error_cnt;
    int         comparisons;
    int         exp_q[$];
    int         s;
    logic [7:0] w;
    ltx_tx_serializer_top #(.WORD_W(8)) DUT (.clk(clk), .rstn(rstn),
        .fast_bit_clock(fast_bit_clock), .slow_word_clock(slow_word_clock),
        .data_in(data_in), .tx_data_p(tx_data_p), .tx_data_n(), .tx_clk_p(), .tx_clk_n());
    ltx_rx_model rx (.fast_bit_clock(fast_bit_clock), .tx_data_p(tx_data_p));
    task automatic end_sim;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp_bit(input logic got, input int e);
        comparisons++;
        if (got !== 1'(e))
        begin
            error_cnt++;
            $display("FAIL %0t got %h exp %h", $time, got, e);
        end
    endtask
    // Model: bit 0 first, eight bits a word
    task automatic push_word(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
            exp_q.push_back(int'(v[i]));
    endtask
    initial
    begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    // Fast clock four times slow, offset 1 ns from clk
    // Rates scaled down from the reference ones so clk can sample them
    initial
    begin
        fast_bit_clock = 1'h0;
        slow_word_clock = 1'h0;
        #1;
        forever
            for (int i = 0; i < 8; i++)
            begin
                fast_bit_clock = (i % 2 == 0);
                slow_word_clock = (i < 4);
                #24;
            end
    end
    initial
    begin
        #30000;
        error_cnt++;
        end_sim;
    end
    initial
    begin
        rstn = 1'h0;
        data_in = 8'hFF;
        void'($urandom(32'hAA73));
        repeat (16) @(posedge clk);
        @(negedge slow_word_clock);
        @(posedge clk);
        rstn <= 1'h1;
        push_word(8'hFF);
        for (int n = 1; n < 20; n++)
        begin
            @(negedge slow_word_clock);
            @(posedge clk);
            w = 8'($urandom());
            data_in <= w;
            push_word(w);
        end
        repeat (300) @(posedge clk);
        s = 0;
        while (s < rx.bits.size() && rx.bits[s] !== 1'h1)
            s++;
        for (int i = 0; i < 128; i++)
            cmp_bit(rx.bits[s + i], exp_q[i]);
        end_sim;
    end
endmodule
`default_nettype wire
